//--- src/ram_block_pkg.sv
package ram_block_pkg;

   // array kinds of the family
   typedef enum logic [1:0] {
      ARRAY_SMALL,
      ARRAY_MEDIUM,
      ARRAY_LARGE
   } array_kind_type;

   // port operating modes
   typedef enum logic [1:0] {
      MODE_SINGLE,
      MODE_SIMPLE_DUAL,
      MODE_TRUE_DUAL,
      MODE_SPLIT_SINGLE
   } ram_mode_type;

   // physical organisation per array kind
   localparam int SMALL_WORDS   = 32;
   localparam int SMALL_WIDTH   = 18;
   localparam int MEDIUM_WORDS  = 128;
   localparam int MEDIUM_WIDTH  = 36;
   localparam int LARGE_WORDS   = 4096;
   localparam int LARGE_WIDTH   = 144;
   localparam int LANE_BITS     = 9;    // byte plus parity bit
   localparam int MAX_WIDTH     = LARGE_WIDTH;
   localparam int MAX_LANES     = MAX_WIDTH / LANE_BITS;
   localparam int MAX_ADDR_BITS = 17;   // narrowest access of large array

   // value of data registers after reset or clear
   localparam logic [MAX_WIDTH-1:0] OUT_CLEAR_VALUE = '0;

   // one port's registered request
   typedef struct packed {
      logic                     wr_en;
      logic                     rd_en;
      logic [MAX_ADDR_BITS-1:0] addr;
      logic [MAX_WIDTH-1:0]     data;
      logic [MAX_LANES-1:0]     lane_en;
   } port_req_type;

endpackage

//--- src/ram_out_stage.sv
`timescale 1ns/1ps

// optional output register with immediate clear
module ram_out_stage
   import ram_block_pkg::*;
#(
   parameter int WIDTH = 36
) (
   input  wire logic             mclk,
   input  wire logic             clear,
   input  wire logic             enable,
   input  wire logic             bypass,
   input  wire logic [WIDTH-1:0] raw,
   output      logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] hold_reg;
   logic [WIDTH-1:0] hold_next;

   // capture the array word when enabled
   always_comb begin
      hold_next = hold_reg;
      if (clear) begin
         hold_next = OUT_CLEAR_VALUE[WIDTH-1:0];
      end else if (enable) begin
         hold_next = raw;
      end
   end

   always_ff @(posedge mclk) begin
      hold_reg <= hold_next;
   end

   // clear reaches the pin at once, not one edge later
   assign q = clear ? OUT_CLEAR_VALUE[WIDTH-1:0] :
              (bypass ? raw : hold_reg);
endmodule

//--- src/ram_block.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE1: small, medium and large array organisations
// RULE2: true dual-port only on medium and large
// RULE3: large used as storage: write, then freeze
// RULE4: preload at configuration except on large
// RULE5: large clears outputs only, others both
// RULE6: write and read widths may differ
// RULE7: inputs registered, internal write strobe
// RULE8: output register bypass gives combinational data
// RULE9: flow-through reads on falling edge
// RULE10: single-port: no same-cycle read and write
// RULE11: simple dual read-during-write old or unknown
// RULE12: medium hosts two half-size single ports
// RULE13: every byte carries a parity bit
// RULE14: byte enables on medium and large
// RULE15: input clear seen next edge, output immediate
// RULE16: small and medium power up cleared
module ram_block
   import ram_block_pkg::*;
#(
   parameter array_kind_type KIND       = ARRAY_MEDIUM,
   parameter ram_mode_type   MODE       = MODE_TRUE_DUAL,
   parameter int             WIDTH_A    = 36,
   parameter int             WIDTH_B    = 36,
   parameter bit             OUT_BYPASS = 1'b0,
   parameter bit             FLOW_THRU  = 1'b0,
   parameter bit             RDW_OLD    = 1'b1,
   parameter bit             PRELOAD    = 1'b0,
   parameter logic [35:0]    PRELOAD_WORD = 36'h0
) (
   input  wire logic                      mclk,
   input  wire logic                      reset,
   input  wire logic                      clear_in,
   input  wire logic                      clear_out,
   input  wire logic                      clken_a,
   input  wire logic                      clken_b,
   input  wire ram_block_pkg::port_req_type req_a,
   input  wire ram_block_pkg::port_req_type req_b,
   output      logic [WIDTH_A-1:0]        q_a,
   output      logic [WIDTH_B-1:0]        q_b,
   output      logic                      collision
);

   // geometry of the chosen array
   localparam int WORDS = (KIND == ARRAY_SMALL)  ? SMALL_WORDS :
                          (KIND == ARRAY_MEDIUM) ? MEDIUM_WORDS :
                                                   LARGE_WORDS;  // see RULE1
   localparam int PHYS  = (KIND == ARRAY_SMALL)  ? SMALL_WIDTH :
                          (KIND == ARRAY_MEDIUM) ? MEDIUM_WIDTH :
                                                   LARGE_WIDTH;
   localparam int BITS  = WORDS * PHYS;
   localparam int BIT_AW = $clog2(BITS);

   // features that depend on array size and mode
   localparam int LANES = PHYS / LANE_BITS;                     // see RULE13
   localparam bit HAS_LANE_EN = (KIND != ARRAY_SMALL);           // see RULE14
   localparam bit TRUE_DUAL = (MODE == MODE_TRUE_DUAL) &&
                              (KIND != ARRAY_SMALL);             // see RULE2
   localparam bit SPLIT = (MODE == MODE_SPLIT_SINGLE) &&
                          (KIND == ARRAY_MEDIUM);                // see RULE12
   localparam bit IN_CLEARABLE = (KIND != ARRAY_LARGE);          // see RULE5
   localparam bit CAN_PRELOAD = PRELOAD && (KIND != ARRAY_LARGE); // see RULE4

   ////////////////////////////////////////////////////////////////////////
   // input registers, one per port
   port_req_type in_a_reg;
   port_req_type in_a_next;
   port_req_type in_b_reg;
   port_req_type in_b_next;
   logic         in_clr;

   assign in_clr = reset || (clear_in && IN_CLEARABLE);          // see RULE5

   // all inputs captured, so writes are synchronous
   always_comb begin
      in_a_next = in_a_reg;
      in_b_next = in_b_reg;
      if (in_clr) begin
         in_a_next = '0;                                         // see RULE15
         in_b_next = '0;
      end else begin
         if (clken_a) begin
            in_a_next = req_a;                                   // see RULE7
         end
         if (clken_b) begin
            in_b_next = req_b;
         end
      end
   end

   always_ff @(posedge mclk) begin
      in_a_reg <= in_a_next;
      in_b_reg <= in_b_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // flow-through read address taken on the falling edge
   logic [MAX_ADDR_BITS-1:0] fall_addr_reg;
   logic [MAX_ADDR_BITS-1:0] fall_addr_next;
   logic                     fall_rd_reg;
   logic                     fall_rd_next;
   localparam bit FLOW = FLOW_THRU && (MODE == MODE_SIMPLE_DUAL) &&
                         (KIND != ARRAY_LARGE);                  // see RULE9

   always_comb begin
      fall_addr_next = fall_addr_reg;
      fall_rd_next   = fall_rd_reg;
      if (in_clr) begin
         fall_addr_next = '0;
         fall_rd_next   = 1'b0;
      end else if (clken_b) begin
         fall_addr_next = req_b.addr;                            // see RULE9
         fall_rd_next   = req_b.rd_en;
      end
   end

   // half-cycle path trades timing margin for no read latency
   always_ff @(negedge mclk) begin
      fall_addr_reg <= fall_addr_next;
      fall_rd_reg   <= fall_rd_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // bit-addressed storage; word size per port sets the scaling
   logic [BITS-1:0] mem_reg;
   logic [BITS-1:0] mem_next;
   logic [BIT_AW-1:0] base_a;
   logic [BIT_AW-1:0] base_b;
   logic [BIT_AW-1:0] base_rd_b;
   logic [MAX_ADDR_BITS-1:0] rd_addr_b;
   logic              wr_a;
   logic              wr_b;
   logic              rd_a;
   logic              rd_b;

   // the second half of a split array is offset by half capacity
   localparam int HALF = BITS / 2;
   // bit span that one port may address; half of the array when split
   localparam int SPAN = SPLIT ? HALF : BITS;

   // a split port wraps inside its own half, never into the other one
   always_comb begin
      rd_addr_b = FLOW ? fall_addr_reg : in_b_reg.addr;
      base_a = BIT_AW'((in_a_reg.addr * WIDTH_A) % SPAN);        // see RULE6
      base_b = BIT_AW'((in_b_reg.addr * WIDTH_B) % SPAN +
                       (SPLIT ? HALF : 0));                      // see RULE12
      base_rd_b = BIT_AW'((rd_addr_b * WIDTH_B) % SPAN +
                          (SPLIT ? HALF : 0));
   end

   // port A writes; port B writes only in two-writer modes
   assign wr_a = in_a_reg.wr_en && (MODE != MODE_SIMPLE_DUAL);
   assign wr_b = in_b_reg.wr_en && (TRUE_DUAL || SPLIT);
   // single-port ports drop a read that shares the write cycle
   assign rd_a = in_a_reg.rd_en && !(wr_a && !TRUE_DUAL);        // see RULE10
   assign rd_b = (FLOW ? fall_rd_reg : in_b_reg.rd_en) &&
                 !(wr_b && !TRUE_DUAL);
   // in simple dual, port A is writer; B reads an overlapping span.
   // mixed widths make equal bases too weak a test: compare the spans
   logic [BIT_AW:0] end_a;
   logic [BIT_AW:0] end_rd_b;
   logic            overlap;

   always_comb begin
      end_a    = {1'b0, base_a} + (BIT_AW+1)'(WIDTH_A);
      end_rd_b = {1'b0, base_rd_b} + (BIT_AW+1)'(WIDTH_B);
      overlap  = ({1'b0, base_a} < end_rd_b) &&
                 ({1'b0, base_rd_b} < end_a);
   end

   assign collision = (MODE == MODE_SIMPLE_DUAL) && in_a_reg.wr_en &&
                      rd_b && overlap;                           // see RULE11

   ////////////////////////////////////////////////////////////////////////
   // per-bit write masks from the byte-lane enables
   logic [MAX_WIDTH-1:0] wmask_a;
   logic [MAX_WIDTH-1:0] wmask_b;
   logic                 strobe_a;

   // port A is the writer in every mode, the simple dual writer included
   assign strobe_a = in_a_reg.wr_en;

   // small array has no lane enables, so its whole word is written;
   // bits above the port width never reach the array
   for (genvar g = 0; g < MAX_WIDTH; g++) begin : g_mask
      assign wmask_a[g] = (g < WIDTH_A) &&
                          (!HAS_LANE_EN ||
                           in_a_reg.lane_en[g / LANE_BITS]);     // see RULE14
      assign wmask_b[g] = (g < WIDTH_B) &&
                          (!HAS_LANE_EN ||
                           in_b_reg.lane_en[g / LANE_BITS]);
   end

   // self-timed strobe: write lands from the registered request
   always_comb begin
      mem_next = mem_reg;
      for (int i = 0; i < MAX_WIDTH; i++) begin
         if (strobe_a && wmask_a[i]) begin
            mem_next[BIT_AW'(base_a + BIT_AW'(i))] = in_a_reg.data[i];
         end                                                     // see RULE7
      end
      for (int i = 0; i < MAX_WIDTH; i++) begin
         if (wr_b && wmask_b[i]) begin
            mem_next[BIT_AW'(base_b + BIT_AW'(i))] = in_b_reg.data[i];
         end                                                     // see RULE14
      end
   end

   // preload word sized to the array; a narrow word cannot feed 144 bits
   logic [PHYS-1:0] preload_word;
   assign preload_word = PHYS'(PRELOAD_WORD);

   // preload models configuration; large array starts unknown
   always_ff @(posedge mclk) begin
      if (reset && CAN_PRELOAD) begin
         mem_reg <= {WORDS{preload_word}};                       // see RULE4
      end else begin
         mem_reg <= mem_next;                                    // see RULE3
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read words; unknown on same-address read unless old data chosen on small or medium
   logic [WIDTH_A-1:0] raw_a;
   logic [WIDTH_B-1:0] raw_b;
   logic               thru_a;
   logic               thru_b;
   logic               rdw_unknown;
   logic [BIT_AW:0]    bit_addr;
   logic               load_a;
   logic               load_b;

   // single-port write shows its own word, lane by lane, with no read
   assign thru_a = wr_a && !TRUE_DUAL;                           // see RULE10
   assign thru_b = wr_b && !TRUE_DUAL;
   // large array has no old-data choice
   assign rdw_unknown = collision && (!RDW_OLD || KIND == ARRAY_LARGE);

   // port A word from the array, or the word being written
   always_comb begin
      raw_a = '0;
      for (int i = 0; i < WIDTH_A; i++) begin
         raw_a[i] = (thru_a && wmask_a[i]) ? in_a_reg.data[i] :
                    mem_reg[BIT_AW'(base_a + BIT_AW'(i))];
      end
   end

   // port B word; only bits under the colliding write go unknown
   always_comb begin
      raw_b    = '0;
      bit_addr = '0;
      for (int i = 0; i < WIDTH_B; i++) begin
         bit_addr = {1'b0, base_rd_b} + (BIT_AW+1)'(i);
         raw_b[i] = (thru_b && wmask_b[i]) ? in_b_reg.data[i] :
                    mem_reg[BIT_AW'(base_rd_b + BIT_AW'(i))];
         if (rdw_unknown && bit_addr >= {1'b0, base_a} &&
             bit_addr < end_a) begin
            raw_b[i] = 1'bx;                                     // see RULE11
         end
      end
   end

   // a write-through word loads the output register like a read
   assign load_a = clken_a && (rd_a || thru_a);
   assign load_b = clken_b && (rd_b || thru_b);

   ////////////////////////////////////////////////////////////////////////
   // output stages; clear acts at once on every array size
   logic out_clr;
   assign out_clr = (reset && KIND != ARRAY_LARGE) || clear_out; // see RULE16

   // port A output stage
   ram_out_stage #(
      .WIDTH (WIDTH_A)
   ) stage_a (
      .mclk   (mclk),
      .clear  (out_clr),                                         // see RULE15
      .enable (load_a),
      .bypass (OUT_BYPASS),                                      // see RULE8
      .raw    (raw_a),
      .q      (q_a)
   );

   // port B output stage; flow-through reads bypass it
   ram_out_stage #(
      .WIDTH (WIDTH_B)
   ) stage_b (
      .mclk   (mclk),
      .clear  (out_clr),                                         // see RULE5
      .enable (load_b),
      .bypass (OUT_BYPASS || FLOW),                              // see RULE9
      .raw    (raw_b),
      .q      (q_b)
   );

endmodule

//--- verif/ram_block_monitor.sv
`timescale 1ns/1ps

// watches one ram block at its ports
module ram_block_monitor
   import ram_block_pkg::*;
#(
   parameter int WIDTH_A = 36,
   parameter int WIDTH_B = 36
) (
   input wire logic                        mclk,
   input wire logic                        reset,
   input wire logic                        clear_in,
   input wire logic                        clear_out,
   input wire logic                        clken_a,
   input wire logic                        clken_b,
   input wire ram_block_pkg::port_req_type req_a,
   input wire ram_block_pkg::port_req_type req_b,
   input wire logic [WIDTH_A-1:0]          q_a,
   input wire logic [WIDTH_B-1:0]          q_b
);
   // one domain: rising edge, quiet during reset
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   property p_oclr;
      clear_out |-> q_a == '0 && q_b == '0;
   endproperty
   a_oclr: assert property (p_oclr)
      else $error("q not zero under output clear");
   property p_rst;
      $fell(reset) |-> q_a == '0 && q_b == '0;
   endproperty
   a_rst: assert property (p_rst)
      else $error("q not zero after reset");
   // idle port must keep its last read word
   property p_hold_a;
      clken_a && !req_a.rd_en && !req_a.wr_en && !clear_out ##1 !clear_out
         |=> clear_out || $stable(q_a);
   endproperty
   a_hold_a: assert property (p_hold_a)
      else $error("q_a moved without a read");
   property p_hold_b;
      clken_b && !req_b.rd_en && !req_b.wr_en && !clear_out ##1 !clear_out
         |=> clear_out || $stable(q_b);
   endproperty
   a_hold_b: assert property (p_hold_b)
      else $error("q_b moved without a read");
   // a new word needs a read taken two edges before
   property p_src_a;
      $changed(q_a) && !clear_out && !$past(clear_out) && $past(clken_a)
         && $past(clken_a, 2) |-> $past(req_a.rd_en, 2);
   endproperty
   a_src_a: assert property (p_src_a)
      else $error("q_a changed off the read pipeline");
   property p_src_b;
      $changed(q_b) && !clear_out && !$past(clear_out) && $past(clken_b)
         && $past(clken_b, 2) |-> $past(req_b.rd_en, 2);
   endproperty
   a_src_b: assert property (p_src_b)
      else $error("q_b changed off the read pipeline");
   property p_iclr;
      clear_in && !clear_out ##1 !clear_out |=> clear_out || $stable(q_a);
   endproperty
   a_iclr: assert property (p_iclr)
      else $error("read survived input clear");
   property p_clken;
      !clken_a && !clear_out |=> clear_out || $stable(q_a);
   endproperty
   a_clken: assert property (p_clken)
      else $error("q_a moved with clock enable low");
endmodule

bind ram_block ram_block_monitor #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B))
   ram_block_monitor_inst (.mclk, .reset, .clear_in, .clear_out, .clken_a,
   .clken_b, .req_a, .req_b, .q_a, .q_b);

//--- verif/fabric_user.sv
`timescale 1ns/1ps

// fabric user logic on port b; can freeze writes until the next reset
module fabric_user
   import ram_block_pkg::*;
(
   input  wire logic                        mclk,
   input  wire logic                        reset,
   input  wire logic                        freeze,
   input  wire ram_block_pkg::port_req_type cmd,
   output      ram_block_pkg::port_req_type req
);
   logic frozen_reg;
   logic frozen_next;
   // once frozen, stays so until the next configuration reset
   always_comb begin
      frozen_next = frozen_reg | freeze;
      req = cmd;
      req.wr_en = cmd.wr_en & ~frozen_next;
   end
   always_ff @(posedge mclk) begin
      frozen_reg <= reset ? 1'b0 : frozen_next;
   end
endmodule

//--- verif/ram_block_tb_top.sv
`timescale 1ns/1ps

module ram_block_tb_top;
   import ram_block_pkg::*;
   typedef struct packed {
      logic        wr_b;
      logic        rd_b;
      logic [6:0]  addr;
      logic [35:0] data;
   } row_type;
   logic         mclk = 1'b0;
   logic         reset = 1'b1;
   logic         clear_in = 1'b0;
   logic         clear_out = 1'b0;
   logic         clken_a = 1'b1;
   logic         clken_b = 1'b1;
   logic         freeze = 1'b0;
   port_req_type idle = '0;
   port_req_type cmd_a = '0;
   port_req_type cmd_b = '0;
   port_req_type req_b;
   port_req_type w;
   port_req_type r;
   logic [35:0]  q_a;
   logic [35:0]  q_b;
   logic [35:0]  m;
   logic         collision;
   int           n_mismatch = 0;
   int           total_checks = 0;
   int           cycles = 0;
   // writer port, reader port, top and bottom addresses
   row_type      rows [4] = '{'{1'b0, 1'b1, 7'h00, 36'h1FF00FF01},
      '{1'b1, 1'b0, 7'h7F, 36'hA5A5A5A5A}, '{1'b0, 1'b0, 7'h40, 36'h0123ABCDE},
      '{1'b1, 1'b1, 7'h01, 36'hFFFFFFFFF}};
   ram_block ram_block_inst (.mclk, .reset, .clear_in, .clear_out, .clken_a,
      .clken_b, .req_a(cmd_a), .req_b, .q_a, .q_b, .collision);
   fabric_user fabric_user_inst (.mclk, .reset, .freeze, .cmd(cmd_b),
      .req(req_b));
   ////////////////////////////////////////////////////////////////////////
   always #4 mclk = ~mclk;
   // hang guard, well above the 78 or so cycles needed
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 400) begin
         n_mismatch = n_mismatch + 1;
         complete_run();
      end
   end
   function automatic port_req_type wr(logic [6:0] a, logic [35:0] d,
                                       logic [3:0] l);
      wr = '0;
      wr.wr_en = 1'b1;
      wr.addr = 17'(a);
      wr.data = 144'(d);
      wr.lane_en = 16'(l);
   endfunction
   function automatic port_req_type rd(logic [6:0] a);
      rd = '0;
      rd.rd_en = 1'b1;
      rd.addr = 17'(a);
   endfunction
   task automatic check(string name, logic [35:0] seen, logic [35:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one request cycle, then idle past the two-edge read latency
   task automatic put(port_req_type ca, port_req_type cb);
      @(negedge mclk);
      cmd_a = ca;
      cmd_b = cb;
      @(negedge mclk);
      cmd_a = idle;
      cmd_b = idle;
      repeat (2) @(negedge mclk);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      check("q_a", q_a, 36'h0);
      check("q_b", q_b, 36'h0);
      foreach (rows[i]) begin
         w = wr(rows[i].addr, rows[i].data, 4'hF);
         r = rd(rows[i].addr);
         put(rows[i].wr_b ? idle : w, rows[i].wr_b ? w : idle);
         put(rows[i].rd_b ? idle : r, rows[i].rd_b ? r : idle);
         check("q", rows[i].rd_b ? q_b : q_a, rows[i].data);
      end
      // both ports busy in the same cycles
      put(wr(7'h02, 36'h111111111, 4'hF), wr(7'h03, 36'h222222222, 4'hF));
      put(rd(7'h03), rd(7'h02));
      check("q_a", q_a, 36'h222222222);
      check("q_b", q_b, 36'h111111111);
      check("collision", 36'(collision), 36'h0);
      // masked lanes keep old bytes and their parity bits
      put(wr(7'h05, 36'h123456789, 4'hF), idle);
      put(wr(7'h05, 36'hFEDCBA987, 4'h5), idle);
      put(rd(7'h05), idle);
      m = {9'h000, 9'h1FF, 9'h000, 9'h1FF};
      m = (36'hFEDCBA987 & m) | (36'h123456789 & ~m);
      check("lanes", q_a, m);
      // output clear must not wait for a clock
      @(negedge mclk);
      clear_out = 1'b1;
      #1;
      check("q_a", q_a, 36'h0);
      check("q_b", q_b, 36'h0);
      @(negedge mclk);
      clear_out = 1'b0;
      put(rd(7'h00), idle);
      clear_in = 1'b1;
      put(rd(7'h05), idle);
      clear_in = 1'b0;
      check("q_a", q_a, 36'h1FF00FF01);
      clken_a = 1'b0;
      put(rd(7'h05), idle);
      clken_a = 1'b1;
      check("q_a", q_a, 36'h1FF00FF01);
      // frozen far side: stored word must survive a write attempt
      freeze = 1'b1;
      put(idle, wr(7'h01, 36'h0, 4'hF));
      put(idle, rd(7'h01));
      check("q_b", q_b, 36'hFFFFFFFFF);
      reset = 1'b1;
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      check("q_a", q_a, 36'h0);
      check("q_b", q_b, 36'h0);
      complete_run();
   end
endmodule
